// *** logic/psa_consts.svh ***
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH
// ----------------------------------------------------------------
// datapath widths
// ----------------------------------------------------------------
`define PSA_VEC_W 128
`define PSA_HALF_W 64
`define PSA_OP_W 5
`define PSA_IMM_W 8
// ----------------------------------------------------------------
// byte shift limits
// ----------------------------------------------------------------
`define PSA_SHIFT_MAX 8'h0f
// ----------------------------------------------------------------
// multi-sum immediate fields
// ----------------------------------------------------------------
`define PSA_MSAD_SRC_LO 0
`define PSA_MSAD_DST_BIT 2
// ----------------------------------------------------------------
// minimum-position result layout
// ----------------------------------------------------------------
`define PSA_MINPOS_IDX_LO 16
// ----------------------------------------------------------------
// reset values and latency
// ----------------------------------------------------------------
`define PSA_RES_RST 128'h0
`define PSA_LATENCY 1
`endif

// *** logic/psa_pkg.sv ***
package psa_pkg;
  // operation selector; the code on the op port is this enum's value
  typedef enum logic [4:0] {
    op_mul_high_unsigned_word,
    op_mul_high_signed_word,
    op_mul_low_word,
    op_widen_mul_unsigned_dword,
    op_mul_low_dword,
    op_widen_mul_signed_dword,
    op_sum_abs_diff_bytes,
    op_multi_sum_abs_diff,
    op_horizontal_min_position,
    op_avg_bytes,
    op_avg_words,
    op_word_multiply_add,
    op_quad_lane_add,
    op_quad_lane_sub,
    op_byte_shift_left_full,
    op_byte_shift_right_full,
    op_logical_test
  } psa_op_type;
  typedef logic [127:0] psa_vec_type;
endpackage

// *** logic/psa_op_if.sv ***
`timescale 1ns/10ps
// operands out to the arithmetic units, results back to the core
interface psa_op_if;
  psa_pkg::psa_vec_type a; // first operand (destination register)
  psa_pkg::psa_vec_type b; // second operand (register or memory)
  psa_pkg::psa_op_type op; // selected operation
  logic wide; // 128-bit form when high
  logic [7:0] imm; // immediate control byte
  psa_pkg::psa_vec_type mul_res; // multiplier unit result
  psa_pkg::psa_vec_type sad_res; // difference unit result
  modport core (output a, b, op, wide, imm, input mul_res, sad_res);
  modport mul (input a, b, op, wide, output mul_res);
  modport sad (input a, b, op, imm, output sad_res);
endinterface // psa_op_if

// *** logic/psa_mul_unit.sv ***
`timescale 1ns/10ps
`include "psa_consts.svh"
// combinational multiplier lanes; the core registers the result
module psa_mul_unit (
  // operand and result bundle
  psa_op_if.mul bus
);
  // ----------------------------------------------------------------
  // lane multipliers
  // ----------------------------------------------------------------
  // one product table per lane width keeps the mux shallow
  always_comb begin
    logic [31:0] p16;
    logic [63:0] p32;
    bus.mul_res = `PSA_RES_RST;
    p16 = 32'h0;
    p32 = 64'h0;
    case (bus.op)
      psa_pkg::op_mul_high_unsigned_word: begin
        for (int i = 0; i < 8; i++) begin
          p16 = 32'(bus.a[16*i +: 16]) * 32'(bus.b[16*i +: 16]);
          bus.mul_res[16*i +: 16] = p16[31:16];
        end
      end
      psa_pkg::op_mul_high_signed_word: begin
        for (int i = 0; i < 8; i++) begin
          p16 = 32'($signed(bus.a[16*i +: 16]) * $signed(bus.b[16*i +: 16]));
          bus.mul_res[16*i +: 16] = p16[31:16];
        end
      end
      psa_pkg::op_mul_low_word: begin
        for (int i = 0; i < 8; i++) begin
          p16 = 32'($signed(bus.a[16*i +: 16]) * $signed(bus.b[16*i +: 16]));
          bus.mul_res[16*i +: 16] = p16[15:0];
        end
      end
      psa_pkg::op_widen_mul_unsigned_dword: begin
        // each 64-bit chunk is its own product
        for (int i = 0; i < 2; i++) begin
          bus.mul_res[64*i +: 64] = 64'(bus.a[64*i +: 32]) *
            64'(bus.b[64*i +: 32]);
        end
      end
      psa_pkg::op_mul_low_dword: begin
        for (int i = 0; i < 4; i++) begin
          p32 = 64'($signed(bus.a[32*i +: 32]) * $signed(bus.b[32*i +: 32]));
          bus.mul_res[32*i +: 32] = p32[31:0];
        end
      end
      psa_pkg::op_widen_mul_signed_dword: begin
        for (int i = 0; i < 2; i++) begin
          bus.mul_res[64*i +: 64] = 64'($signed(bus.a[64*i +: 32]) *
            $signed(bus.b[64*i +: 32]));
        end
      end
      psa_pkg::op_word_multiply_add: begin
        // two signed products summed per dword lane
        for (int i = 0; i < 4; i++) begin
          bus.mul_res[32*i +: 32] =
            32'($signed(bus.a[32*i +: 16]) * $signed(bus.b[32*i +: 16])) +
            32'($signed(bus.a[32*i+16 +: 16]) *
            $signed(bus.b[32*i+16 +: 16]));
        end
      end
      default: begin
        bus.mul_res = `PSA_RES_RST; // not a multiply
      end
    endcase
  end
endmodule // psa_mul_unit

// *** logic/psa_sad_unit.sv ***
`timescale 1ns/10ps
`include "psa_consts.svh"
// sums of absolute byte differences and the minimum search
module psa_sad_unit (
  // operand and result bundle
  psa_op_if.sad bus
);
  // absolute difference of two unsigned bytes
  function automatic logic [7:0] abs_diff(input logic [7:0] x,
    input logic [7:0] y);
    abs_diff = (x > y) ? 8'(x - y) : 8'(y - x);
  endfunction
  // ----------------------------------------------------------------
  // difference sums and minimum search
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] acc;
    logic [15:0] best;
    logic [2:0] best_idx;
    int src_base;
    int dst_base;
    acc = 16'h0;
    best = 16'hffff;
    best_idx = 3'h0;
    src_base = 4 * int'(bus.imm[`PSA_MSAD_SRC_LO +: 2]);
    dst_base = 4 * int'(bus.imm[`PSA_MSAD_DST_BIT]);
    bus.sad_res = `PSA_RES_RST;
    case (bus.op)
      psa_pkg::op_sum_abs_diff_bytes: begin
        // one word per 64-bit half, upper words stay zero
        for (int h = 0; h < 2; h++) begin
          acc = 16'h0;
          for (int k = 0; k < 8; k++) begin
            acc = acc + 16'(abs_diff(bus.a[64*h+8*k +: 8],
              bus.b[64*h+8*k +: 8]));
          end
          bus.sad_res[64*h +: 16] = acc;
        end
      end
      psa_pkg::op_multi_sum_abs_diff: begin
        // sliding window over a against one fixed block of b
        for (int w = 0; w < 8; w++) begin
          acc = 16'h0;
          for (int k = 0; k < 4; k++) begin
            acc = acc + 16'(abs_diff(bus.a[8*(dst_base+w+k) +: 8],
              bus.b[8*(src_base+k) +: 8]));
          end
          bus.sad_res[16*w +: 16] = acc;
        end
      end
      psa_pkg::op_horizontal_min_position: begin
        // strict compare so the lowest index wins a tie
        for (int w = 0; w < 8; w++) begin
          if (bus.b[16*w +: 16] < best || w == 0) begin
            best = bus.b[16*w +: 16];
            best_idx = 3'(w);
          end
        end
        bus.sad_res[15:0] = best;
        bus.sad_res[`PSA_MINPOS_IDX_LO +: 3] = best_idx;
      end
      default: begin
        bus.sad_res = `PSA_RES_RST; // not a difference op
      end
    endcase
  end
endmodule // psa_sad_unit

// *** logic/psa_simd_alu.sv ***
`timescale 1ns/10ps
`include "psa_consts.svh"
module psa_simd_alu (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // operation request
  input wire logic OP_VALID,
  input wire logic [`PSA_OP_W-1:0] OP_CODE,
  input wire logic OP_WIDE,
  input wire logic OP_MEM_SEL,
  input wire logic [`PSA_IMM_W-1:0] OP_IMM,
  // operands
  input wire logic [`PSA_VEC_W-1:0] SRC_A,
  input wire logic [`PSA_VEC_W-1:0] SRC_B,
  input wire logic [`PSA_VEC_W-1:0] MEM_B,
  // vector result
  output logic RES_VALID,
  output logic RES_WRITE,
  output logic [`PSA_VEC_W-1:0] RES_DATA,
  // condition flags
  output logic FLAG_VALID,
  output logic ZERO_FLAG,
  output logic CARRY_FLAG
);
  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  psa_op_if ops (); // bundle shared with the two units
  psa_pkg::psa_op_type op; // decoded operation
  logic code_ok; // code names a real operation
  logic [`PSA_VEC_W-1:0] src_b; // chosen second operand
  assign op = psa_pkg::psa_op_type'(OP_CODE);
  assign code_ok = OP_CODE <= 5'(psa_pkg::op_logical_test);
  assign src_b = OP_MEM_SEL ? MEM_B : SRC_B;
  assign ops.a = SRC_A;
  assign ops.b = src_b;
  assign ops.op = op;
  assign ops.wide = OP_WIDE;
  assign ops.imm = OP_IMM;

  // multiplier lanes
  psa_mul_unit u_mul (
    .bus (ops.mul)
  );
  // difference lanes
  psa_sad_unit u_sad (
    .bus (ops.sad)
  );

  // ----------------------------------------------------------------
  // average, quad arithmetic and byte shifts
  // ----------------------------------------------------------------
  // rounding average; the 9-bit or 17-bit sum's carry lands on top
  function automatic logic [`PSA_VEC_W-1:0] avg_lanes(
    input logic [`PSA_VEC_W-1:0] x, input logic [`PSA_VEC_W-1:0] y,
    input logic words);
    logic [16:0] s;
    avg_lanes = `PSA_RES_RST;
    s = 17'h0;
    for (int i = 0; i < 16; i++) begin
      if (words) begin
        if (i < 8) begin
          s = 17'(x[16*i +: 16]) + 17'(y[16*i +: 16]) + 17'h1;
          avg_lanes[16*i +: 16] = s[16:1];
        end
      end else begin
        s = 17'(x[8*i +: 8]) + 17'(y[8*i +: 8]) + 17'h1;
        avg_lanes[8*i +: 8] = s[8:1];
      end
    end
  endfunction

  logic [`PSA_VEC_W-1:0] avg_res; // average result
  logic [`PSA_VEC_W-1:0] quad_res; // quad add or subtract result
  logic [6:0] shift_bits; // byte count turned into bits
  logic shift_big; // count beyond the register
  logic [`PSA_VEC_W-1:0] shift_res; // byte shift result
  logic narrow_form; // op issued in its 64-bit register form (OP_WIDE low)
  logic [`PSA_VEC_W-1:0] lane_res; // selected result before masking
  logic [`PSA_VEC_W-1:0] vec_res; // masked vector result
  logic is_test; // logical test, flags only
  logic test_zero; // and of operands is zero
  logic test_carry; // and-not of operands is zero

  assign avg_res = avg_lanes(SRC_A, src_b, op == psa_pkg::op_avg_words);
  // plain modular adders; signedness does not change the bits
  assign quad_res = (op == psa_pkg::op_quad_lane_sub) ?
    {64'(SRC_A[127:64] - src_b[127:64]),
     64'(SRC_A[63:0] - src_b[63:0])} :
    {64'(SRC_A[127:64] + src_b[127:64]),
     64'(SRC_A[63:0] + src_b[63:0])};
  assign shift_bits = {OP_IMM[3:0], 3'h0};
  assign shift_big = OP_IMM > `PSA_SHIFT_MAX;
  assign shift_res = shift_big ? `PSA_RES_RST :
    (op == psa_pkg::op_byte_shift_left_full) ?
    (SRC_A << shift_bits) : (SRC_A >> shift_bits);

  // ----------------------------------------------------------------
  // result selection
  // ----------------------------------------------------------------
  // 128-bit-only ops ignore the form bit
  assign narrow_form = !OP_WIDE && op != psa_pkg::op_mul_low_dword &&
    op != psa_pkg::op_widen_mul_signed_dword &&
    op != psa_pkg::op_multi_sum_abs_diff &&
    op != psa_pkg::op_horizontal_min_position &&
    op != psa_pkg::op_byte_shift_left_full &&
    op != psa_pkg::op_byte_shift_right_full;
  always_comb begin
    case (op)
      psa_pkg::op_avg_bytes, psa_pkg::op_avg_words: begin
        lane_res = avg_res;
      end
      psa_pkg::op_quad_lane_add, psa_pkg::op_quad_lane_sub: begin
        lane_res = quad_res;
      end
      psa_pkg::op_byte_shift_left_full,
      psa_pkg::op_byte_shift_right_full: begin
        lane_res = shift_res;
      end
      psa_pkg::op_sum_abs_diff_bytes, psa_pkg::op_multi_sum_abs_diff,
      psa_pkg::op_horizontal_min_position: begin
        lane_res = ops.sad_res;
      end
      default: begin
        lane_res = ops.mul_res; // multiplies, zero otherwise
      end
    endcase
  end
  // a 64-bit register form leaves the upper half clear
  assign vec_res = narrow_form ? {64'h0, lane_res[63:0]} : lane_res;
  assign is_test = code_ok && op == psa_pkg::op_logical_test;
  assign test_zero = ~|(SRC_A & src_b);
  assign test_carry = ~|(src_b & ~SRC_A);

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic res_valid_reg;
  logic res_write_reg;
  logic [`PSA_VEC_W-1:0] res_data_reg;
  logic flag_valid_reg;
  logic zero_flag_reg;
  logic carry_flag_reg;
  logic res_write_next; // a vector result is written
  assign res_write_next = OP_VALID && code_ok && !is_test;

  // valid strobe per request, write strobe only for known codes other than the test
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      res_valid_reg <= 1'b0;
      res_write_reg <= 1'b0;
      flag_valid_reg <= 1'b0;
    end else begin
      res_valid_reg <= OP_VALID;
      res_write_reg <= res_write_next;
      flag_valid_reg <= OP_VALID && is_test;
    end
  end
  // result data holds across a test, which writes nothing
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      res_data_reg <= `PSA_RES_RST;
    end else if (res_write_next) begin
      res_data_reg <= vec_res;
    end
  end
  // only the logical test touches the flags
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      zero_flag_reg <= 1'b0;
      carry_flag_reg <= 1'b0;
    end else if (OP_VALID && is_test) begin
      zero_flag_reg <= test_zero;
      carry_flag_reg <= test_carry;
    end
  end
  assign RES_VALID = res_valid_reg;
  assign RES_WRITE = res_write_reg;
  assign RES_DATA = res_data_reg;
  assign FLAG_VALID = flag_valid_reg;
  assign ZERO_FLAG = zero_flag_reg;
  assign CARRY_FLAG = carry_flag_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // copies of the last request, read only by the checks
  logic [127:0] a_q;
  logic [127:0] b_q;
  logic [7:0] imm_q;
  logic wide_q;
  psa_pkg::psa_op_type op_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      a_q <= 128'h0;
      b_q <= 128'h0;
      imm_q <= 8'h0;
      wide_q <= 1'b0;
      op_q <= psa_pkg::op_mul_high_unsigned_word;
    end else begin
      a_q <= SRC_A;
      b_q <= src_b;
      imm_q <= OP_IMM;
      wide_q <= OP_WIDE;
      op_q <= op;
    end
  end
  logic chk; // a written result is on the outputs
  assign chk = RES_VALID && RES_WRITE;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  property p_mul_high;
    chk && op_q == psa_pkg::op_mul_high_unsigned_word |->
      RES_DATA[31:16] == 16'((32'(a_q[31:16]) * 32'(b_q[31:16])) >> 16);
  endproperty
  a_mul_high: assert property (p_mul_high) else $error("high mul");
  property p_mul_low;
    chk && op_q == psa_pkg::op_mul_low_word |->
      RES_DATA[15:0] == 16'(a_q[15:0] * b_q[15:0]);
  endproperty
  a_mul_low: assert property (p_mul_low) else $error("low mul");
  property p_widen_u;
    chk && op_q == psa_pkg::op_widen_mul_unsigned_dword |->
      RES_DATA[63:0] == 64'(a_q[31:0]) * 64'(b_q[31:0]);
  endproperty
  a_widen_u: assert property (p_widen_u) else $error("widen mul");
  property p_widen_hi;
    chk && op_q == psa_pkg::op_widen_mul_unsigned_dword |->
      RES_DATA[127:64] ==
        (wide_q ? 64'(a_q[95:64]) * 64'(b_q[95:64]) : 64'h0);
  endproperty
  a_widen_hi: assert property (p_widen_hi) else $error("upper chunk");
  property p_mul_dword;
    chk && op_q == psa_pkg::op_mul_low_dword |->
      RES_DATA[63:32] == 32'(a_q[63:32] * b_q[63:32]);
  endproperty
  a_mul_dword: assert property (p_mul_dword) else $error("dword mul");
  property p_widen_s;
    chk && op_q == psa_pkg::op_widen_mul_signed_dword |->
      $signed(RES_DATA[63:0]) == $signed(a_q[31:0]) * $signed(b_q[31:0]);
  endproperty
  a_widen_s: assert property (p_widen_s) else $error("signed widen");
  property p_sad_upper;
    chk && op_q == psa_pkg::op_sum_abs_diff_bytes |->
      RES_DATA[63:16] == 48'h0 && RES_DATA[127:80] == 48'h0;
  endproperty
  a_sad_upper: assert property (p_sad_upper) else $error("sad upper");
  property p_avg;
    chk && op_q == psa_pkg::op_avg_bytes |->
      RES_DATA[7:0] == 8'((9'(a_q[7:0]) + 9'(b_q[7:0]) + 9'h1) >> 1);
  endproperty
  a_avg: assert property (p_avg) else $error("byte average");
  property p_madd;
    chk && op_q == psa_pkg::op_word_multiply_add |->
      RES_DATA[31:0] == 32'($signed(a_q[15:0]) * $signed(b_q[15:0]) +
      $signed(a_q[31:16]) * $signed(b_q[31:16]));
  endproperty
  a_madd: assert property (p_madd) else $error("multiply add");
  property p_quad;
    chk && op_q == psa_pkg::op_quad_lane_sub |->
      RES_DATA[63:0] == 64'(a_q[63:0] - b_q[63:0]);
  endproperty
  a_quad: assert property (p_quad) else $error("quad sub");
  property p_shift_zero;
    chk && imm_q > 8'h0f && (op_q == psa_pkg::op_byte_shift_left_full ||
      op_q == psa_pkg::op_byte_shift_right_full) |-> RES_DATA == 128'h0;
  endproperty
  a_shift_zero: assert property (p_shift_zero) else $error("shift");
  property p_test_hold;
    OP_VALID && is_test |=> !RES_WRITE && FLAG_VALID && $stable(RES_DATA);
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("test wrote");
  property p_test_flags;
    FLAG_VALID |-> ZERO_FLAG == ~|(a_q & b_q) && CARRY_FLAG == ~|(b_q & ~a_q);
  endproperty
  a_test_flags: assert property (p_test_flags) else $error("flags");
  // byte distance worked out apart from the difference unit
  function automatic logic [15:0] byte_gap(input logic [7:0] x, y);
    byte_gap = (x > y) ? 16'(x - y) : 16'(y - x);
  endfunction
  property p_sad_narrow;
    chk && op_q == psa_pkg::op_sum_abs_diff_bytes && !wide_q |->
      RES_DATA[127:64] == 64'h0;
  endproperty
  a_sad_narrow: assert property (p_sad_narrow) else $error("sad half");
  // word zero of the sliding sums, window picked by the control byte
  property p_msad;
    chk && op_q == psa_pkg::op_multi_sum_abs_diff |-> RES_DATA[15:0] ==
      byte_gap(a_q[32*imm_q[2] +: 8], b_q[32*imm_q[1:0] +: 8]) +
      byte_gap(a_q[32*imm_q[2]+8 +: 8], b_q[32*imm_q[1:0]+8 +: 8]) +
      byte_gap(a_q[32*imm_q[2]+16 +: 8], b_q[32*imm_q[1:0]+16 +: 8]) +
      byte_gap(a_q[32*imm_q[2]+24 +: 8], b_q[32*imm_q[1:0]+24 +: 8]);
  endproperty
  a_msad: assert property (p_msad) else $error("multi sum");
  property p_minpos;
    chk && op_q == psa_pkg::op_horizontal_min_position |->
      RES_DATA[15:0] == b_q[16*RES_DATA[18:16] +: 16] &&
      RES_DATA[15:0] <= b_q[15:0] && RES_DATA[127:19] == 109'h0;
  endproperty
  a_minpos: assert property (p_minpos) else $error("min position");
  // the carry out of each chunk is simply lost
  property p_quad_add;
    chk && op_q == psa_pkg::op_quad_lane_add |->
      RES_DATA[63:0] == 64'(a_q[63:0] + b_q[63:0]);
  endproperty
  a_quad_add: assert property (p_quad_add) else $error("quad add");
  property p_shift_left;
    chk && op_q == psa_pkg::op_byte_shift_left_full && imm_q <= 8'h0f |->
      RES_DATA == a_q << (8 * imm_q);
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("left");
  property p_shift_right;
    chk && op_q == psa_pkg::op_byte_shift_right_full && imm_q <= 8'h0f |->
      RES_DATA == a_q >> (8 * imm_q);
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("right");

  c_test: cover property (FLAG_VALID && CARRY_FLAG);
  c_sad: cover property (chk && op_q == psa_pkg::op_multi_sum_abs_diff);
  c_shift: cover property (chk && op_q == psa_pkg::op_byte_shift_left_full);
  c_back: cover property (chk [*3]);
  c_narrow: cover property (chk && !wide_q);
endmodule // psa_simd_alu

// *** dv/psa_issue_model.sv ***
`timescale 1ns/10ps
// stands for the core's issue and register file logic
module psa_issue_model (
  // clock
  input wire logic clk,
  // request
  output logic op_valid,
  output logic [4:0] op_code,
  output logic op_wide,
  output logic op_mem_sel,
  output logic [7:0] op_imm,
  // operands
  output psa_pkg::psa_vec_type src_a,
  output psa_pkg::psa_vec_type src_b,
  output psa_pkg::psa_vec_type mem_b
);
  // quiet request at time zero
  initial begin
    op_valid = 1'h0;
    op_code = 5'h00;
    op_wide = 1'h0;
    op_mem_sel = 1'h0;
    op_imm = 8'h00;
    src_a = 128'h0;
    src_b = 128'h0;
    mem_b = 128'h0;
  end

  // ----------------------------------------------------------------
  // one request, held for one taking edge
  // ----------------------------------------------------------------
  task automatic issue(input logic [4:0] code, input logic wd, ms,
    input logic [7:0] im, input psa_pkg::psa_vec_type a, b);
    @(posedge clk);
    op_valid <= 1'h1;
    op_code <= code;
    op_wide <= wd;
    op_mem_sel <= ms;
    op_imm <= im;
    src_a <= a;
    // the unused source carries junk so a wrong select shows
    src_b <= ms ? ~b : b;
    mem_b <= ms ? b : ~b;
    @(posedge clk);
    // taken here; scrambled afterwards so stale operands are not trusted
    op_valid <= 1'h0;
    op_code <= ~code;
    src_a <= ~a;
    src_b <= b ^ {8{16'h5a5a}};
    mem_b <= ~b;
    // strobes stand one cycle: look just after the taking edge
    #1;
  endtask
endmodule // psa_issue_model

// *** dv/psa_simd_alu_test.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t got %h expected %h", $time, got, exp); \
    end \
  end
module psa_simd_alu_test;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  logic ref_clk;
  logic rst_b;
  logic op_valid, op_wide, op_mem_sel;
  logic [4:0] op_code;
  logic [7:0] op_imm;
  psa_pkg::psa_vec_type src_a, src_b, mem_b, res_data;
  logic res_valid, res_write, flag_valid, zero_flag, carry_flag;
  int bad_count;
  int cmp_count;
  logic wd, ms; // form and memory select for the next request
  psa_pkg::psa_vec_type va, vb, ve, vk;

  psa_issue_model mdl (.clk(ref_clk), .op_valid(op_valid),
    .op_code(op_code), .op_wide(op_wide), .op_mem_sel(op_mem_sel),
    .op_imm(op_imm), .src_a(src_a), .src_b(src_b), .mem_b(mem_b));

  psa_simd_alu DUT (.REF_CLK(ref_clk), .RST_B(rst_b),
    .OP_VALID(op_valid), .OP_CODE(op_code), .OP_WIDE(op_wide),
    .OP_MEM_SEL(op_mem_sel), .OP_IMM(op_imm), .SRC_A(src_a),
    .SRC_B(src_b), .MEM_B(mem_b), .RES_VALID(res_valid),
    .RES_WRITE(res_write), .RES_DATA(res_data),
    .FLAG_VALID(flag_valid), .ZERO_FLAG(zero_flag),
    .CARRY_FLAG(carry_flag));

  // 40 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one written-result operation on va, vb compared against ve
  task automatic run(input logic [4:0] code, input logic [7:0] im);
    mdl.issue(code, wd, ms, im, va, vb);
    `CHK(res_valid, 1'h1)
    `CHK(res_write, 1'h1)
    `CHK(res_data, ve)
  endtask

  // reference for the eight four-byte sums, built from byte offsets
  function automatic psa_pkg::psa_vec_type msad_ref(
    input psa_pkg::psa_vec_type a, b, input logic [2:0] im);
    psa_pkg::psa_vec_type r;
    logic [7:0] x, y;
    r = 128'h0;
    for (int w = 0; w < 8; w++) begin
      for (int k = 0; k < 4; k++) begin
        x = a[8*(4*im[2]+w+k) +: 8];
        y = b[8*(4*im[1:0]+k) +: 8];
        r[16*w +: 16] = r[16*w +: 16] + 16'(x > y ? x - y : y - x);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_mul_word();
    va = {8{16'h8000}};
    vb = {4{32'h0003_ffff}};
    ve = {4{32'h0001_7fff}};
    run(psa_pkg::op_mul_high_unsigned_word, 8'h00);
    ve = {4{32'hfffe_0000}};
    run(psa_pkg::op_mul_high_signed_word, 8'h00);
    ve = {8{16'h8000}};
    run(psa_pkg::op_mul_low_word, 8'h00);
  endtask

  task automatic t_mul_dword();
    va = {64'h9_0000_0002, 64'h7_ffff_ffff};
    vb = {64'h8_0000_0003, 64'h6_ffff_ffff};
    ve = {64'h6, 64'hffff_fffe_0000_0001};
    run(psa_pkg::op_widen_mul_unsigned_dword, 8'h00);
    wd = 1'h0;
    ve = {64'h0, 64'hffff_fffe_0000_0001};
    run(psa_pkg::op_widen_mul_unsigned_dword, 8'h00);
    wd = 1'h1;
    va = {4{32'h8000_0001}};
    vb = {4{32'h0000_0003}};
    ve = {4{32'h8000_0003}};
    run(psa_pkg::op_mul_low_dword, 8'h00);
    va = {2{64'h1_ffff_ffff}};
    vb = {2{64'h2_0000_0005}};
    ve = {2{64'hffff_ffff_ffff_fffb}};
    run(psa_pkg::op_widen_mul_signed_dword, 8'h00);
  endtask

  task automatic t_sad();
    va = {16{8'h10}};
    vb = {64'h0, 64'h0020_1010_1010_10ff};
    ve = {64'h80, 64'h10f};
    run(psa_pkg::op_sum_abs_diff_bytes, 8'h00);
    wd = 1'h0;
    ve = {64'h0, 64'h10f};
    run(psa_pkg::op_sum_abs_diff_bytes, 8'h00);
    wd = 1'h1;
    for (int i = 0; i < 16; i++) begin
      va[8*i +: 8] = 8'(i * 29);
      vb[8*i +: 8] = 8'(255 - i * 13);
    end
    // every block and offset choice of the control byte
    for (int im = 0; im < 8; im++) begin
      ve = msad_ref(va, vb, 3'(im));
      run(psa_pkg::op_multi_sum_abs_diff, 8'(im));
    end
    // a tie between lanes 1 and 3 must report the lower index
    vb = 128'hffff_ffff_ffff_ffff_0003_0009_0003_0005;
    ve = 128'h1_0003;
    run(psa_pkg::op_horizontal_min_position, 8'h00);
  endtask

  task automatic t_avg_madd();
    ms = 1'h1;
    va = {4{32'h00ff_ffff}};
    vb = {4{32'h01ff_fffe}};
    ve = {4{32'h01ff_ffff}};
    run(psa_pkg::op_avg_bytes, 8'h00);
    ve = {4{32'h017f_ffff}};
    run(psa_pkg::op_avg_words, 8'h00);
    ms = 1'h0;
    va = {2{64'h0002_0003_ffff_8000}};
    vb = {2{64'h0004_0005_8000_8000}};
    ve = {2{64'h0000_0017_4000_8000}};
    run(psa_pkg::op_word_multiply_add, 8'h00);
  endtask

  task automatic t_quad_shift();
    logic [7:0] n [5] = '{8'h00, 8'h03, 8'h0f, 8'h10, 8'hff};
    va = {64'h0, 64'hffff_ffff_ffff_ffff};
    vb = {64'h1, 64'h2};
    ve = {64'h1, 64'h1};
    run(psa_pkg::op_quad_lane_add, 8'h00);
    ve = {64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_fffd};
    run(psa_pkg::op_quad_lane_sub, 8'h00);
    va = 128'h0f0e0d0c0b0a09080706050403020100;
    foreach (n[i]) begin
      ve = (n[i] > 8'h0f) ? 128'h0 : va << (8 * n[i]);
      run(psa_pkg::op_byte_shift_left_full, n[i]);
      ve = (n[i] > 8'h0f) ? 128'h0 : va >> (8 * n[i]);
      run(psa_pkg::op_byte_shift_right_full, n[i]);
    end
  endtask

  task automatic t_test();
    va = 128'h5;
    vb = 128'h3;
    ve = 128'h8;
    run(psa_pkg::op_quad_lane_add, 8'h00);
    vk = res_data; // the last result must survive tests and bad codes
    mdl.issue(psa_pkg::op_logical_test, 1'h1, 1'h0, 8'h00, 128'hf0, 128'h0f);
    `CHK(res_write, 1'h0)
    `CHK(flag_valid, 1'h1)
    `CHK(res_data, vk)
    `CHK({zero_flag, carry_flag}, 2'h2)
    mdl.issue(psa_pkg::op_logical_test, 1'h1, 1'h0, 8'h00, 128'hff, 128'h0f);
    `CHK({zero_flag, carry_flag}, 2'h1)
    // an unknown code is answered but writes nothing
    mdl.issue(5'h1f, 1'h1, 1'h0, 8'h00, 128'h0, 128'h0);
    `CHK({res_valid, res_write, flag_valid}, 3'h4)
    `CHK(res_data, vk)
    `CHK({zero_flag, carry_flag}, 2'h1)
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    bad_count = 0;
    cmp_count = 0;
    wd = 1'h1;
    ms = 1'h0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'h1;
    #1;
    `CHK({res_valid, res_write, flag_valid, res_data}, 131'h0)
    t_mul_word();
    t_mul_dword();
    t_sad();
    t_avg_madd();
    t_quad_shift();
    t_test();
    report_and_stop();
  end

  // about 90 cycles of work; this span leaves a wide margin
  initial begin
    #(25 * 4000);
    bad_count++;
    report_and_stop();
  end
endmodule // psa_simd_alu_test
